// [ufs_defs.svh]
`ifndef UFS_DEFS_SVH
`define UFS_DEFS_SVH

`define UFS_WORDS 512
`define UFS_ADDR_W 9
`define UFS_DATA_W 16
`define UFS_SECTOR_WORDS 256
`define UFS_ERASED_WORD 16'hffff

`define UFS_CLK_PERIOD_NS 25
`define UFS_RUN_HOLD_MS 500
`define UFS_RUN_HOLD_CYC (`UFS_RUN_HOLD_MS * 1000000 / `UFS_CLK_PERIOD_NS)
`define UFS_PROG_TIME_NS 2000
`define UFS_PROG_CYC ((`UFS_PROG_TIME_NS + `UFS_CLK_PERIOD_NS - 1) / `UFS_CLK_PERIOD_NS)
`define UFS_ERASE_TIME_NS 50000
`define UFS_ERASE_CYC ((`UFS_ERASE_TIME_NS + `UFS_CLK_PERIOD_NS - 1) / `UFS_CLK_PERIOD_NS)
`define UFS_REPROG_TIME_NS 10000
`define UFS_REPROG_CYC ((`UFS_REPROG_TIME_NS + `UFS_CLK_PERIOD_NS - 1) / `UFS_CLK_PERIOD_NS)
`define UFS_OSC_HALF_NS 100
`define UFS_OSC_HALF_CYC (`UFS_OSC_HALF_NS / `UFS_CLK_PERIOD_NS)

`define UFS_PIN_WR 0
`define UFS_PIN_ER 1
`define UFS_PIN_DCLK 2
`define UFS_PIN_DSH 3
`define UFS_PIN_DIN 4
`define UFS_PIN_ACLK 5
`define UFS_PIN_ASH 6
`define UFS_PIN_AIN 7
`define UFS_PIN_OSC 8
`define UFS_PIN_RPQ 9
`define UFS_PIN_N 10

`endif

// [ufs_pkg.sv]
`include "ufs_defs.svh"

package ufs_pkg;

	typedef enum logic [2:0] {
		UFS_SEQ_IDLE = 3'h1,
		UFS_SEQ_PROG = 3'h2,
		UFS_SEQ_ERASE = 3'h4
	} ufs_seq_t;

	typedef enum logic [2:0] {
		UFS_RP_RUN = 3'h1,
		UFS_RP_HOLD = 3'h2,
		UFS_RP_REPROG = 3'h4
	} ufs_rp_t;

	typedef struct packed {
		logic erase;
		logic [`UFS_ADDR_W-1:0] addr;
		logic [`UFS_DATA_W-1:0] data;
	} ufs_req_t;

endpackage : ufs_pkg

// [ufs_top.sv]
`timescale 1ns/10ps
`include "ufs_defs.svh"

// Functional notes
// - write_start rising edge stores data register at address; busy until done.
// - sector_clear_start rising edge erases sector of address msb; busy until done.
// - ring enable or reprogramming runs oscillator output; otherwise output stays high.
// - each data clock edge gives new serial_data_out value per shift select.
// - write or erase requests while busy start nothing.
// - reprogramming raises live flag, holds 500 ms before reprogramming.
// - address and data registers are not retained across reprogramming.
// - array holds 512 words of 16 bits in two sectors.
// - shift select high shifts serial address bit in per address clock.
// - shift select low increments address by one per address clock.
// - operations act on the location held in the address register.
// - data register is 16 bits, shifts from serial in toward serial out.
// - shift select low loads addressed word in parallel into data register.
// - most significant data bit appears first on serial_data_out.
// - internal sequencer times writes and erases without outside help.
// - erase only whole sectors, never single words.
// - busy rises when a request is queued, falls when algorithm completes.
// - address register is 9 bits wide.
// - incrementing highest address wraps to zero.
// - shifting enters serial in at lsb and moves msb out.
module ufs_top
	import ufs_pkg::*;
#(
	parameter int unsigned RUN_HOLD_CYCLES = `UFS_RUN_HOLD_CYC,
	parameter int unsigned BUF_DEPTH = 2
)
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic write_start_i,
	input wire logic sector_clear_start_i,
	input wire logic ring_clock_enable_i,
	input wire logic data_reg_clock_i,
	input wire logic data_shift_select_i,
	input wire logic serial_data_in_i,
	input wire logic addr_reg_clock_i,
	input wire logic addr_shift_select_i,
	input wire logic serial_addr_in_i,
	input wire logic reprogram_request_i,
	output logic busy_o,
	output logic internal_clock_out_o,
	output logic serial_data_out_o,
	output logic live_reprogram_flag_o
);

	localparam int PW = $clog2(BUF_DEPTH);
	// 512 x 16 array, two sectors
	logic [`UFS_DATA_W-1:0] mem [`UFS_WORDS];
	logic [`UFS_PIN_N-1:0] pin_raw, sync1, sync2, sync3, rise;
	logic [`UFS_ADDR_W-1:0] addr, next_addr;
	logic [`UFS_DATA_W-1:0] dreg, next_dreg;
	ufs_req_t buf_ent [BUF_DEPTH];
	logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [PW:0] buf_cnt, next_buf_cnt;
	logic sdo, next_sdo, in_valid, in_ready, out_valid, out_ready, push, pop;
	ufs_seq_t seq, next_seq;
	ufs_req_t in_req, cur, next_cur;
	logic [31:0] seq_tmr, next_seq_tmr, rp_tmr, next_rp_tmr;
	logic [7:0] er_idx, next_er_idx, osc_cnt, next_osc_cnt;
	logic [`UFS_ADDR_W-1:0] mem_wa;
	logic [`UFS_DATA_W-1:0] mem_wd;
	ufs_rp_t rp, next_rp;
	logic mem_we, reg_clear, osc_run, osc, next_osc;

	function automatic logic [31:0] tmr_dec(input logic [31:0] t);
		tmr_dec = (t == 32'h0) ? 32'h0 : t - 32'h1;
	endfunction : tmr_dec

	assign pin_raw = {reprogram_request_i, ring_clock_enable_i, serial_addr_in_i,
		addr_shift_select_i, addr_reg_clock_i, serial_data_in_i, data_shift_select_i,
		data_reg_clock_i, sector_clear_start_i, write_start_i};

	// every pin is asynchronous; third stage only remembers the previous level
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			addr <= '0;
			dreg <= '0;
			sdo <= 1'b0;
			wr_ptr <= '0;
			rd_ptr <= '0;
			buf_cnt <= '0;
			seq <= UFS_SEQ_IDLE;
			cur <= '0;
			seq_tmr <= '0;
			er_idx <= '0;
			rp <= UFS_RP_RUN;
			rp_tmr <= '0;
			osc <= 1'b1;
			osc_cnt <= '0;
		end
		else
		begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			addr <= next_addr;
			dreg <= next_dreg;
			sdo <= next_sdo;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			buf_cnt <= next_buf_cnt;
			seq <= next_seq;
			cur <= next_cur;
			seq_tmr <= next_seq_tmr;
			er_idx <= next_er_idx;
			rp <= next_rp;
			rp_tmr <= next_rp_tmr;
			osc <= next_osc;
			osc_cnt <= next_osc_cnt;
		end
	end
	assign rise = sync2 & ~sync3;

	// registers are dropped at the end of reprogramming, never kept across it
	assign reg_clear = (rp == UFS_RP_REPROG) && (rp_tmr == 32'h0);

	always_comb
	begin
		next_addr = addr;
		next_dreg = dreg;
		next_sdo = sdo;
		if (reg_clear)
		begin
			next_addr = '0;
			next_dreg = '0;
			next_sdo = 1'b0;
		end
		else
		begin
			if (rise[`UFS_PIN_ACLK])
			begin
				if (sync2[`UFS_PIN_ASH])
					next_addr = {addr[`UFS_ADDR_W-2:0], sync2[`UFS_PIN_AIN]};
				else
					next_addr = `UFS_ADDR_W'(addr + 1'b1);
			end
			if (rise[`UFS_PIN_DCLK])
			begin
				// lsb in, msb toward serial out
				if (sync2[`UFS_PIN_DSH])
					next_dreg = {dreg[`UFS_DATA_W-2:0], sync2[`UFS_PIN_DIN]};
				else
					next_dreg = mem[addr];
				// new value each data clock edge, msb first
				next_sdo = next_dreg[`UFS_DATA_W-1];
			end
		end
	end
	assign serial_data_out_o = sdo;

	// request buffer: captures the address and data at the request edge
	// operation uses address register contents
	assign in_req = '{erase: ~rise[`UFS_PIN_WR], addr: addr, data: dreg};
	// no request taken while busy or reprogramming
	assign in_valid = (rise[`UFS_PIN_WR] | rise[`UFS_PIN_ER]) & ~busy_o & (rp == UFS_RP_RUN);
	assign in_ready = (buf_cnt != (PW+1)'(BUF_DEPTH));
	assign push = in_valid & in_ready;
	assign out_valid = (buf_cnt != '0);
	assign out_ready = (seq == UFS_SEQ_IDLE);
	assign pop = out_valid & out_ready;

	always_comb
	begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_buf_cnt = buf_cnt;
		if (push)
			next_wr_ptr = PW'((wr_ptr + 1'b1) % BUF_DEPTH);
		if (pop)
			next_rd_ptr = PW'((rd_ptr + 1'b1) % BUF_DEPTH);
		if (push && !pop)
			next_buf_cnt = buf_cnt + 1'b1;
		else if (pop && !push)
			next_buf_cnt = buf_cnt - 1'b1;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (push)
			buf_ent[wr_ptr] <= in_req;
	end

	always_comb
	begin
		next_seq = seq;
		next_cur = cur;
		next_seq_tmr = tmr_dec(seq_tmr);
		next_er_idx = er_idx;
		mem_we = 1'b0;
		mem_wa = cur.addr;
		mem_wd = cur.data;
		case (seq)
			UFS_SEQ_IDLE:
			begin
				if (pop)
				begin
					next_cur = buf_ent[rd_ptr];
					next_er_idx = '0;
					next_seq = buf_ent[rd_ptr].erase ? UFS_SEQ_ERASE : UFS_SEQ_PROG;
					next_seq_tmr = buf_ent[rd_ptr].erase ? 32'(`UFS_ERASE_CYC) : 32'(`UFS_PROG_CYC);
				end
			end
			UFS_SEQ_PROG:
			begin
				// word is written when the program time has run out
				if (seq_tmr == 32'h0)
				begin
					mem_we = 1'b1;
					next_seq = UFS_SEQ_IDLE;
				end
			end
			UFS_SEQ_ERASE:
			begin
				// whole sector of the address msb, one word per cycle, last word when the erase time has run out
				mem_wa = {cur.addr[`UFS_ADDR_W-1], er_idx};
				mem_wd = `UFS_ERASED_WORD;
				mem_we = (er_idx != 8'hff) || (seq_tmr != 32'h0) ? 1'b0 : 1'b1;
				if (er_idx != 8'hff)
				begin
					mem_we = 1'b1;
					next_er_idx = er_idx + 8'h1;
				end
				else if (seq_tmr == 32'h0)
					next_seq = UFS_SEQ_IDLE;
			end
			default:
				next_seq = UFS_SEQ_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	// busy covers a queued request as well as the running one
	assign busy_o = (seq != UFS_SEQ_IDLE) || out_valid;

	// live flag, wait in UFS_RP_HOLD state before reprogramming
	always_comb
	begin
		next_rp = rp;
		next_rp_tmr = tmr_dec(rp_tmr);
		case (rp)
			UFS_RP_RUN:
			begin
				if (rise[`UFS_PIN_RPQ])
				begin
					next_rp = UFS_RP_HOLD;
					next_rp_tmr = 32'(RUN_HOLD_CYCLES);
				end
			end
			UFS_RP_HOLD:
			begin
				if (rp_tmr == 32'h0)
				begin
					next_rp = UFS_RP_REPROG;
					next_rp_tmr = 32'(`UFS_REPROG_CYC);
				end
			end
			UFS_RP_REPROG:
			begin
				if (rp_tmr == 32'h0)
					next_rp = UFS_RP_RUN;
			end
			default:
				next_rp = UFS_RP_RUN;
		endcase
	end
	assign live_reprogram_flag_o = (rp != UFS_RP_RUN);

	// oscillator; reprogramming enables it regardless of the pin
	assign osc_run = sync2[`UFS_PIN_OSC] | live_reprogram_flag_o;
	always_comb
	begin
		next_osc = 1'b1;
		next_osc_cnt = '0;
		if (osc_run)
		begin
			next_osc = osc;
			next_osc_cnt = osc_cnt + 8'h1;
			if (osc_cnt == 8'(`UFS_OSC_HALF_CYC - 1))
			begin
				next_osc = ~osc;
				next_osc_cnt = '0;
			end
		end
	end
	assign internal_clock_out_o = osc;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	addr_inc_a: assert property (rise[`UFS_PIN_ACLK] && !sync2[`UFS_PIN_ASH] && !reg_clear
		|=> addr == `UFS_ADDR_W'($past(addr) + 1'b1)) else $error("address did not increment");
	addr_shift_a: assert property (rise[`UFS_PIN_ACLK] && sync2[`UFS_PIN_ASH] && !reg_clear
		|=> addr[0] == $past(sync2[`UFS_PIN_AIN]) && addr[8:1] == $past(addr[7:0]))
		else $error("address shift wrong");
	data_shift_a: assert property (rise[`UFS_PIN_DCLK] && sync2[`UFS_PIN_DSH] && !reg_clear
		|=> serial_data_out_o == $past(dreg[14]) && dreg[0] == $past(sync2[`UFS_PIN_DIN]))
		else $error("data shift wrong");
	data_load_a: assert property (rise[`UFS_PIN_DCLK] && !sync2[`UFS_PIN_DSH] && !reg_clear
		|=> dreg == $past(mem[addr]) && serial_data_out_o == dreg[15])
		else $error("parallel load wrong");
	busy_start_a: assert property (push |=> busy_o [*2]) else $error("busy not raised");
	busy_ignore_a: assert property (seq != UFS_SEQ_IDLE |-> !out_valid)
		else $error("request taken while busy");
	prog_done_a: assert property (seq == UFS_SEQ_PROG && seq_tmr == 32'h0
		|=> mem[$past(cur.addr)] == $past(cur.data) && seq == UFS_SEQ_IDLE)
		else $error("program did not store word");
	erase_sector_a: assert property (seq == UFS_SEQ_ERASE && mem_we
		|-> mem_wa[8] == cur.addr[8] && mem_wd == `UFS_ERASED_WORD) else $error("erase outside sector");
	osc_idle_a: assert property (!osc_run ##1 !osc_run |-> internal_clock_out_o)
		else $error("oscillator output not high");
	flag_hold_a: assert property ($rose(live_reprogram_flag_o) |-> live_reprogram_flag_o [*8])
		else $error("live flag dropped early");

endmodule : ufs_top

// [ufs_fabric_model.sv]
`timescale 1ns/10ps
module ufs_fabric_model (
	input wire logic core_clk_i,
	input wire logic busy_i,
	input wire logic live_i,
	input wire logic sdo_i,
	output logic addr_reg_clock_o,
	output logic addr_shift_select_o,
	output logic serial_addr_in_o,
	output logic data_reg_clock_o,
	output logic data_shift_select_o,
	output logic serial_data_in_o
);
	initial
	begin
		{addr_reg_clock_o, addr_shift_select_o, serial_addr_in_o} = 3'h0;
		{data_reg_clock_o, data_shift_select_o, serial_data_in_o} = 3'h0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#2;
	endtask : tick

	// link clocks rest low between frames; 200 ns period
	task automatic link_edge(input bit is_addr);
		int i;
		for (i = 0; i < 4000 && busy_i !== 1'b0; i++)
			tick(1);
		// a busy that never ends fails the run instead of clocking anyway
		if (i == 4000)
		begin
			ufs_top_tb.chk(1'b1, 1'b0);
			ufs_top_tb.results();
		end
		if (live_i !== 1'b0)
			return;
		tick(4);
		if (is_addr)
			addr_reg_clock_o = 1'b1;
		else
			data_reg_clock_o = 1'b1;
		tick(4);
		addr_reg_clock_o = 1'b0;
		data_reg_clock_o = 1'b0;
	endtask : link_edge

	task automatic shift_addr(input logic [8:0] a);
		addr_shift_select_o = 1'b1;
		for (int i = 8; i >= 0; i--)
		begin
			serial_addr_in_o = a[i];
			link_edge(1'b1);
		end
		// released line shows the inverse, not a stale bit
		serial_addr_in_o = ~a[0];
	endtask : shift_addr

	task automatic incr_addr();
		addr_shift_select_o = 1'b0;
		link_edge(1'b1);
	endtask : incr_addr

	task automatic shift_data(input logic [15:0] d);
		data_shift_select_o = 1'b1;
		for (int i = 15; i >= 0; i--)
		begin
			serial_data_in_o = d[i];
			link_edge(1'b0);
		end
		serial_data_in_o = ~d[0];
	endtask : shift_data

	// non-destructive read: parallel load, then fifteen shifts
	task automatic read_word(output logic [15:0] w);
		data_shift_select_o = 1'b0;
		link_edge(1'b0);
		tick(1);
		w[15] = sdo_i;
		data_shift_select_o = 1'b1;
		for (int i = 14; i >= 0; i--)
		begin
			link_edge(1'b0);
			tick(1);
			w[i] = sdo_i;
		end
	endtask : read_word
endmodule : ufs_fabric_model

// [ufs_top_tb.sv]
`timescale 1ns/10ps
module ufs_top_tb;
	logic core_clk_i, sys_rst_i, write_start_i, sector_clear_start_i;
	logic ring_clock_enable_i, reprogram_request_i;
	logic data_reg_clock_i, data_shift_select_i, serial_data_in_i;
	logic addr_reg_clock_i, addr_shift_select_i, serial_addr_in_i;
	logic busy_o, internal_clock_out_o, serial_data_out_o, live_reprogram_flag_o;
	int err_count = 0;
	int n_tests = 0;

	ufs_top #(.RUN_HOLD_CYCLES(50)) DUT (.core_clk_i, .sys_rst_i, .write_start_i,
		.sector_clear_start_i, .ring_clock_enable_i, .data_reg_clock_i, .data_shift_select_i,
		.serial_data_in_i, .addr_reg_clock_i, .addr_shift_select_i, .serial_addr_in_i,
		.reprogram_request_i, .busy_o, .internal_clock_out_o, .serial_data_out_o,
		.live_reprogram_flag_o);
	ufs_fabric_model fab (.core_clk_i, .busy_i(busy_o), .live_i(live_reprogram_flag_o),
		.sdo_i(serial_data_out_o), .addr_reg_clock_o(addr_reg_clock_i),
		.addr_shift_select_o(addr_shift_select_i), .serial_addr_in_o(serial_addr_in_i),
		.data_reg_clock_o(data_reg_clock_i), .data_shift_select_o(data_shift_select_i),
		.serial_data_in_o(serial_data_in_i));

	initial
	begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#2;
	endtask : tick

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic chk(input logic seen, input logic exp);
		check({15'h0, seen}, {15'h0, exp});
	endtask : chk

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	// 0 program, 1 sector erase, 2 reprogram
	task automatic pulse(input int which);
		if (which == 0)
			write_start_i = 1'b1;
		else if (which == 1)
			sector_clear_start_i = 1'b1;
		else
			reprogram_request_i = 1'b1;
		tick(4);
		{write_start_i, sector_clear_start_i, reprogram_request_i} = 3'h0;
		tick(4);
	endtask : pulse

	task automatic wait_idle(output int n);
		for (n = 0; n < 5000 && (busy_o | live_reprogram_flag_o) !== 1'b0; n++)
			tick(1);
		if (n == 5000)
		begin
			chk(1'b1, 1'b0);
			results();
		end
	endtask : wait_idle

	task automatic write_word(input logic [8:0] a, input logic [15:0] d);
		int n;
		fab.shift_addr(a);
		fab.shift_data(d);
		pulse(0);
		chk(busy_o, 1'b1);
		wait_idle(n);
	endtask : write_word

	task automatic read_at(input logic [8:0] a, input logic [15:0] exp);
		logic [15:0] w;
		fab.shift_addr(a);
		fab.read_word(w);
		check(w, exp);
	endtask : read_at

	task automatic test_osc();
		int n;
		logic last;
		chk(internal_clock_out_o, 1'b1);
		ring_clock_enable_i = 1'b1;
		tick(8);
		n = 0;
		last = internal_clock_out_o;
		repeat (64)
		begin
			tick(1);
			n += int'(internal_clock_out_o !== last);
			last = internal_clock_out_o;
		end
		check(16'(n), 16'h0010);
		ring_clock_enable_i = 1'b0;
		tick(8);
		n = 0;
		repeat (16)
		begin
			tick(1);
			n += int'(internal_clock_out_o !== 1'b1);
		end
		check(16'(n), 16'h0000);
		$display("done oscillator");
	endtask : test_osc

	task automatic test_rw();
		logic [15:0] w;
		write_word(9'h0a5, 16'hc3a5);
		write_word(9'h000, 16'h5a01);
		write_word(9'h1ff, 16'h8e71);
		read_at(9'h0a5, 16'hc3a5);
		read_at(9'h1ff, 16'h8e71);
		fab.incr_addr();
		fab.read_word(w);
		check(w, 16'h5a01);
		$display("done program and read");
	endtask : test_rw

	task automatic test_erase();
		int n;
		fab.shift_addr(9'h1ff);
		pulse(1);
		chk(busy_o, 1'b1);
		wait_idle(n);
		read_at(9'h1ff, 16'hffff);
		read_at(9'h000, 16'h5a01);
		$display("done erase");
	endtask : test_erase

	task automatic test_refuse();
		int n;
		fab.shift_addr(9'h0a5);
		fab.shift_data(16'h1234);
		pulse(0);
		pulse(1);
		chk(busy_o, 1'b1);
		wait_idle(n);
		tick(3000);
		chk(busy_o, 1'b0);
		read_at(9'h0a5, 16'h1234);
		read_at(9'h000, 16'h5a01);
		$display("done refused request");
	endtask : test_refuse

	task automatic test_reprog();
		int n;
		pulse(2);
		chk(live_reprogram_flag_o, 1'b1);
		fab.incr_addr();
		wait_idle(n);
		chk(n >= 430 && n <= 460, 1'b1);
		chk(serial_data_out_o, 1'b0);
		$display("done reprogramming");
	endtask : test_reprog

	initial
	begin
		{sys_rst_i, write_start_i, sector_clear_start_i} = 3'h4;
		{ring_clock_enable_i, reprogram_request_i} = 2'h0;
		tick(10);
		sys_rst_i = 1'b0;
		tick(2);
		check({13'h0, busy_o, serial_data_out_o, live_reprogram_flag_o}, 16'h0000);
		test_osc();
		test_rw();
		test_erase();
		test_refuse();
		test_reprog();
		results();
	end
endmodule : ufs_top_tb
